// File: sar_ctrl_defs.svh
// Timing constants and field positions for the converter control block
`ifndef SAR_CTRL_DEFS_SVH
`define SAR_CTRL_DEFS_SVH

`define CLK_FREQ_MHZ        25
`define POWERUP_TIME_NS     1500
`define CONV_TIME_NS        4000
`define CONV_MAX_NS         5000
`define POWERUP_CYCLES      ((`POWERUP_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define CONV_CYCLES         ((`CONV_TIME_NS * `CLK_FREQ_MHZ) / 1000)
`define RESULT_BITS         8
`define RESULT_MSB          7
`define SHIFT_RESET_VALUE   8'h00
`define TIMER_WIDTH         8

`endif

// File: sar_ctrl_pkg.sv
// Types for the converter control block
package sar_ctrl_pkg;

   typedef enum logic [1:0] {
      PWR_DOWN   = 2'b00,
      POWERING   = 2'b01,
      IDLE_UP    = 2'b10,
      CONVERTING = 2'b11
   } pwr_state_t;

endpackage : sar_ctrl_pkg

// File: sar_approx.sv
// Successive-approximation engine: one result bit decided per step
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctrl_defs.svh"

module sar_approx #(
   parameter int WIDTH = `RESULT_BITS
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             start,
   input  wire logic             step,
   input  wire logic [WIDTH-1:0] sample_code,
   output logic      [WIDTH-1:0] result,
   output logic                  finished
);

   typedef struct packed {
      logic [WIDTH-1:0] trial;
      logic [WIDTH-1:0] bit_mask;
      logic [WIDTH-1:0] sample;
      logic [WIDTH-1:0] result;
      logic             busy;
   } approx_t;

   approx_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      if (start) begin
         s_next.sample   = sample_code;
         s_next.bit_mask = {1'b1, {(WIDTH-1){1'b0}}};
         s_next.trial    = '0;
         s_next.busy     = 1'b1;
      end else if (s_reg.busy && step) begin
         // Keep the bit if the trial level does not exceed the held sample
         if ((s_reg.trial | s_reg.bit_mask) <= s_reg.sample)
            s_next.trial = s_reg.trial | s_reg.bit_mask;
         s_next.bit_mask = s_reg.bit_mask >> 1;
         if (s_reg.bit_mask[0]) begin
            s_next.busy   = 1'b0;
            s_next.result = ((s_reg.trial | s_reg.bit_mask) <= s_reg.sample)
                            ? (s_reg.trial | s_reg.bit_mask) : s_reg.trial;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign result   = s_reg.result;
   assign finished = !s_reg.busy;

endmodule : sar_approx
`default_nettype wire

// File: sar_ctrl.sv
// Convert-start sequencing, power control and serial readout of the converter
//
// Contract
// - Result is straight binary, step Vref/256
// - Starts powered down; rising edge powers up
// - Falling edge holds sample, starts conversion
// - Conversion finishes within 5 us
// - At end, latch result and sample pin
// - Pin low at end powers down
// - Early falling edge waits out power-up
// - Serial output enabled only after rising edge
// - Rising edge clears counter; extra clocks ignored
// - Bits launched on rising serial clock edges
// - Eighth falling edge tristates and disarms
// - Early readout gives previous, late gives current
// - Result load waits for readout to finish
// - Readout works while powered down
// - Free-running or burst serial clock accepted
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctrl_defs.svh"

module sar_ctrl #(
   parameter int POWERUP_CYCLES = `POWERUP_CYCLES,
   parameter int CONV_CYCLES    = `CONV_CYCLES
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire logic                     convert_start_n,
   input  wire logic                     sclk,
   input  wire logic [`RESULT_MSB:0]     sample_code,
   output logic                          dout_o,
   output logic                          dout_oe,
   output logic                          powered,
   output logic                          tracking,
   output logic                          conv_done
);

   // Bit-decision spacing so the approximation ends inside the conversion time
   // Needs one clock per result bit after the start cycle, so CONV_CYCLES may not drop below 9
   localparam int STEP_CYCLES = CONV_CYCLES / `RESULT_BITS;

   typedef struct packed {
      logic [1:0]                cs_sync;
      logic                      cs_last;
      logic [1:0]                sck_sync;
      logic                      sck_last;
      sar_ctrl_pkg::pwr_state_t  state;
      logic [`TIMER_WIDTH-1:0]   timer;
      logic [`TIMER_WIDTH-1:0]   step_cnt;
      logic                      start_pending;
      logic                      conv_go;
      logic                      done_pulse;
      logic                      load_pending;
      logic                      port_armed;
      logic [3:0]                bit_cnt;
      logic [`RESULT_MSB:0]      shift;
      logic                      dout;
      logic                      oe;
   } ctrl_t;

   ctrl_t s_reg, s_next;

   // Edge decode on a synchronised level and its one-cycle history
   function automatic logic edge_up(input logic now_lvl, input logic last_lvl);
      edge_up = now_lvl && !last_lvl;
   endfunction : edge_up

   function automatic logic edge_down(input logic now_lvl, input logic last_lvl);
      edge_down = !now_lvl && last_lvl;
   endfunction : edge_down

   // Both ways into a conversion arm the same counters; one place keeps the
   // power-up path and the idle path from drifting apart
   function automatic ctrl_t start_conversion(input ctrl_t s);
      start_conversion          = s;
      start_conversion.state    = sar_ctrl_pkg::CONVERTING;
      start_conversion.conv_go  = 1'b1;
      start_conversion.timer    = `TIMER_WIDTH'(CONV_CYCLES - 1);
      start_conversion.step_cnt = `TIMER_WIDTH'(STEP_CYCLES - 1);
   endfunction : start_conversion

   logic                 cs_rise;
   logic                 cs_fall;
   logic                 sck_rise;
   logic                 sck_fall;
   logic                 reading;
   logic [`RESULT_MSB:0] sar_result;
   logic                 sar_finished;
   logic                 sar_step;

   assign cs_rise  = edge_up(s_reg.cs_sync[1], s_reg.cs_last);
   assign cs_fall  = edge_down(s_reg.cs_sync[1], s_reg.cs_last);
   assign sck_rise = edge_up(s_reg.sck_sync[1], s_reg.sck_last);
   assign sck_fall = edge_down(s_reg.sck_sync[1], s_reg.sck_last);
   assign sar_step = (s_reg.state == sar_ctrl_pkg::CONVERTING) &&
                     (s_reg.step_cnt == '0);
   // A readout is under way once the first bit has gone out
   // It stays busy until the eighth falling edge, so a load never splits a byte
   assign reading  = s_reg.oe && (s_reg.bit_cnt != 4'h0);

   // The engine only decides bits; pacing comes from the step counter here
   sar_approx #(
      .WIDTH(`RESULT_BITS)
   ) u_approx (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .start       (s_reg.conv_go),
      .step        (sar_step),
      .sample_code (sample_code),
      .result      (sar_result),
      .finished    (sar_finished)
   );

   always_comb begin
      s_next            = s_reg;
      // Two-stage synchronisers; only the second stage and its history are read
      s_next.cs_sync    = {s_reg.cs_sync[0], convert_start_n};
      s_next.cs_last    = s_reg.cs_sync[1];
      s_next.sck_sync   = {s_reg.sck_sync[0], sclk};
      s_next.sck_last   = s_reg.sck_sync[1];
      s_next.conv_go    = 1'b0;
      s_next.done_pulse = 1'b0;

      unique case (s_reg.state)
         sar_ctrl_pkg::PWR_DOWN: begin
            if (cs_rise) begin
               s_next.state = sar_ctrl_pkg::POWERING;
               s_next.timer = `TIMER_WIDTH'(POWERUP_CYCLES - 1);
               s_next.start_pending = 1'b0;
            end
         end
         sar_ctrl_pkg::POWERING: begin
            if (cs_fall)
               s_next.start_pending = 1'b1;
            if (s_reg.timer != '0) begin
               s_next.timer = s_reg.timer - `TIMER_WIDTH'(1);
            end else if (s_reg.start_pending || cs_fall) begin
               // Power-up has run its full time before the sample is held
               s_next = start_conversion(s_next);
            end else begin
               s_next.state = sar_ctrl_pkg::IDLE_UP;
            end
         end
         sar_ctrl_pkg::IDLE_UP: begin
            if (cs_fall) begin
               s_next = start_conversion(s_next);
            end
         end
         sar_ctrl_pkg::CONVERTING: begin
            s_next.step_cnt = (s_reg.step_cnt == '0)
                              ? `TIMER_WIDTH'(STEP_CYCLES - 1)
                              : s_reg.step_cnt - `TIMER_WIDTH'(1);
            if (s_reg.timer != '0) begin
               s_next.timer = s_reg.timer - `TIMER_WIDTH'(1);
            end else begin
               s_next.done_pulse   = 1'b1;
               s_next.load_pending = 1'b1;
               // Pin level at the decision instant picks the mode
               s_next.state = s_reg.cs_sync[1] ? sar_ctrl_pkg::IDLE_UP
                                               : sar_ctrl_pkg::PWR_DOWN;
            end
         end
      endcase

      // Serial port runs in every power state; only the rising pin edge rearms it
      if (cs_rise) begin
         s_next.port_armed = 1'b1;
         s_next.bit_cnt    = 4'h0;
         s_next.oe         = 1'b0;
      end else if (s_reg.port_armed && s_reg.bit_cnt < 4'h8) begin
         if (sck_rise) begin
            s_next.oe      = 1'b1;
            s_next.dout    = s_reg.shift[`RESULT_MSB - s_reg.bit_cnt[2:0]];
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
         end
      end else if (s_reg.port_armed && s_reg.bit_cnt == 4'h8 && sck_fall) begin
         // Disarmed after a full byte: further clocks are ignored until the pin
         // rises again, which a continuous clock would otherwise restart
         s_next.oe         = 1'b0;
         s_next.bit_cnt    = 4'h0;
         s_next.port_armed = 1'b0;
      end

      // Result enters the shift register only between readouts, and only once the
      // engine has settled its last bit: when the final step lands on the edge at
      // which the timer ends, the engine shows the new code in the same cycle as load_pending
      if (s_reg.load_pending && sar_finished && !reading &&
          !(s_next.oe && s_next.bit_cnt != 4'h0)) begin
         s_next.shift        = sar_result;
         s_next.load_pending = 1'b0;
      end
   end

   // Synchronous reset; pin history resets low, the level the host holds at
   // power-on, so no false edge is seen when reset lets go

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg          <= '0;
         s_reg.cs_sync  <= 2'b00;
         s_reg.state    <= sar_ctrl_pkg::PWR_DOWN;
         s_reg.shift    <= `SHIFT_RESET_VALUE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Power and track levels decode straight from the state register
   assign dout_o    = s_reg.dout;
   assign dout_oe   = s_reg.oe;
   assign powered   = (s_reg.state != sar_ctrl_pkg::PWR_DOWN);
   assign tracking  = (s_reg.state != sar_ctrl_pkg::CONVERTING);
   assign conv_done = s_reg.done_pulse;

endmodule : sar_ctrl
`default_nettype wire

// File: sar_ctrl_checker.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctrl_defs.svh"
module sar_ctrl_checker #(
   parameter int POWERUP_CYCLES = `POWERUP_CYCLES,
   parameter int CONV_CYCLES    = `CONV_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic convert_start_n,
   input wire logic sclk,
   input wire logic dout_oe,
   input wire logic powered,
   input wire logic tracking,
   input wire logic conv_done
);
   localparam int CLO = CONV_CYCLES - 4;
   localparam int CHI = CONV_CYCLES + 4;
   logic [3:0] pin_reg;
   logic [7:0] up_reg;
   // Cycles spent powered, saturating, to judge the power-up wait
   always_ff @(posedge ref_clk) begin
      pin_reg <= {pin_reg[2:0], convert_start_n};
      up_reg  <= (rst || !powered) ? 8'h00 : up_reg + {7'h00, up_reg != 8'hff};
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_CONV_TIME: assert property ($fell(tracking) |-> ##[CLO:CHI] conv_done)
      else $error("conversion time wrong");
   AST_DONE_PULSE: assert property (conv_done |=> !conv_done)
      else $error("done pulse too long");
   AST_UP_TIME: assert property ($fell(tracking) |-> up_reg >= POWERUP_CYCLES - 2)
      else $error("converted before power-up");
   AST_PWR_DOWN: assert property (conv_done && pin_reg == 4'h0 |-> ##[0:2] !powered)
      else $error("no power-down");
   AST_STAY_UP: assert property (conv_done && pin_reg == 4'hf |=> powered ##1 powered)
      else $error("powered down in fast mode");
   AST_WAKE: assert property ($rose(convert_start_n) |-> ##[1:6] powered)
      else $error("no power-up");
   AST_OE_RISE: assert property ($rose(dout_oe) |-> $past(sclk) && $past(sclk, 2))
      else $error("output enabled off a clock rise");
   AST_OE_FALL: assert property ($fell(dout_oe) |-> !$past(sclk) && !$past(sclk, 2))
      else $error("output released off a clock fall");
endmodule : sar_ctrl_checker
bind sar_ctrl sar_ctrl_checker #(.POWERUP_CYCLES(POWERUP_CYCLES), .CONV_CYCLES(CONV_CYCLES)) chk (
   .ref_clk(ref_clk), .rst(rst), .convert_start_n(convert_start_n), .sclk(sclk),
   .dout_oe(dout_oe), .powered(powered), .tracking(tracking), .conv_done(conv_done));
`default_nettype wire

// File: sar_host_model.sv
// Host model: drives convert start and a burst serial clock, collects bits
`timescale 1ns/1ps
`default_nettype none
module sar_host_model (
   input  wire logic ref_clk,
   input  wire logic dout_line,
   output logic      convert_start_n,
   output logic      sclk
);
   // Pin held low from power-on; clock stands low outside bursts
   initial begin
      convert_start_n = 1'b0;
      sclk = 1'b0;
   end
   task automatic set_pin(input logic lvl);
      @(posedge ref_clk);
      convert_start_n <= lvl;
   endtask : set_pin
   // Burst of n periods of 8 cycles; callers never raise the pin meanwhile
   task automatic read(input int n, output logic [7:0] d);
      d = 8'h00;
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         sclk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         sclk <= 1'b0;
         // Sampled two cycles into the four-cycle low phase, clear of the synchroniser delay
         repeat (2) @(posedge ref_clk);
         if (i < 8) d = {d[6:0], dout_line};
         @(posedge ref_clk);
      end
   endtask : read
endmodule : sar_host_model
`default_nettype wire

// File: sar_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctrl_defs.svh"
module sar_ctrl_tb;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] sample_code = 8'h00;
   logic [7:0] prev, code, d;
   logic       junk = 1'b0;
   logic       oe_seen = 1'b0;
   wire logic  convert_start_n, sclk, dout_o, dout_oe, powered, tracking, conv_done;
   int         fail_count = 0;
   int         n_tests = 0;
   // A released data line toggles, so a stale bit cannot pass
   wire logic  dout_line = dout_oe ? dout_o : junk;
   sar_ctrl #(.POWERUP_CYCLES(8), .CONV_CYCLES(16)) dut (.ref_clk(ref_clk), .rst(rst),
      .convert_start_n(convert_start_n), .sclk(sclk), .sample_code(sample_code),
      .dout_o(dout_o), .dout_oe(dout_oe), .powered(powered), .tracking(tracking),
      .conv_done(conv_done));
   sar_host_model host (.ref_clk(ref_clk), .dout_line(dout_line),
      .convert_start_n(convert_start_n), .sclk(sclk));
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      junk <= ~junk;
      if (dout_oe === 1'b1) oe_seen <= 1'b1;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   task automatic wait_done;
      for (int i = 0; i < 64; i++) begin
         @(posedge ref_clk);
         if (conv_done === 1'b1) return;
      end
      check("conv_done", 8'h01, 8'h00);
      end_of_test;
   endtask : wait_done
   task automatic readout(input logic [7:0] exp);
      host.read(8 + $urandom % 3, d);
      check("result", exp, d);
      repeat (3) @(posedge ref_clk);
      check("dout_oe", 8'h00, {7'h00, dout_oe});
   endtask : readout
   initial begin
      void'($urandom(62232));
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      check("powered", 8'h00, {7'h00, powered});
      host.read(8, d);
      check("oe_seen", 8'h00, {7'h00, oe_seen});
      prev = `SHIFT_RESET_VALUE;
      // Eight auto power-down rounds, then eight that stay powered
      for (int k = 0; k < 16; k++) begin
         code = 8'($urandom);
         sample_code <= code;
         if (convert_start_n === 1'b0) begin
            host.set_pin(1'b1);
            repeat (2 + $urandom % 10) @(posedge ref_clk);
         end
         host.set_pin(1'b0);
         if (k >= 8) begin
            repeat (2) @(posedge ref_clk);
            host.set_pin(1'b1);
         end
         if ($urandom % 2) readout(prev);
         else begin
            wait_done;
            readout(code);
         end
         check("powered", {7'h00, k >= 8}, {7'h00, powered});
         prev = code;
      end
      end_of_test;
   end
endmodule : sar_ctrl_tb
`default_nettype wire
